// *** common/pcie_fc_pkg.sv ***
/*
  Constants and state type for the PCIe master and flow-control block.
  Assumes a 25 MHz core clock and a 32-bit APB register port.
*/
package pcie_fc_pkg;

  localparam int CLK_MHZ = 25;

  // APB map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_DEVN = 8'h08;
  localparam int CTRL_BLK     = 0;
  localparam int CTRL_XSYNC   = 1;
  localparam int CTRL_ANYDLLP = 2;
  localparam int CTRL_SWRST   = 3;
  localparam int STAT_MEN     = 0;
  localparam int STAT_POISON  = 1;
  localparam int STAT_CTO     = 2;

  // Advertised receive credits
  localparam logic [7:0]  ADV_PH  = 8'h02;
  localparam logic [11:0] ADV_PD  = 12'h010;
  localparam logic [7:0]  ADV_NPH = 8'h02;
  localparam logic [11:0] ADV_NPD = 12'h002;

  // Upstream header credits assumed after link init
  localparam logic [7:0] UP_CRED_INIT = 8'h08;
  localparam logic [3:0] UPD_ALL      = 4'hf;

  // Timing
  localparam int UPD_US    = 30;
  localparam int UPD_XS_US = 120;
  localparam logic [11:0] UPD_LAST    = 12'(UPD_US * CLK_MHZ - 1);
  localparam logic [11:0] UPD_XS_LAST = 12'(UPD_XS_US * CLK_MHZ - 1);
  localparam int WD_US      = 200;
  localparam int WD_CYC     = WD_US * CLK_MHZ;
  localparam int MS_CYC     = 1000 * CLK_MHZ;
  localparam int CTO_MIN_MS = 10;
  localparam int CTO_MAX_MS = 50;
  localparam logic [4:0] CTO_LAST = 5'(CTO_MIN_MS * 2 - 1);

  // Client tags
  localparam logic [4:0] TAG_RX_DATA  = 5'h00;
  localparam logic [4:0] TAG_RX_DRD   = 5'h01;
  localparam logic [4:0] TAG_RX_DWB   = 5'h02;
  localparam logic [4:0] TAG_TX_DRD   = 5'h04;
  localparam logic [4:0] TAG_TX_DWB   = 5'h05;
  localparam logic [4:0] TAG_TX_DRD2  = 5'h06;
  localparam logic [4:0] TAG_TX_DWB2  = 5'h07;
  localparam logic [4:0] TAG_TX_DAT0  = 5'h08;
  localparam logic [4:0] TAG_TX_DAT1  = 5'h09;
  localparam logic [4:0] TAG_TX_DAT2  = 5'h0a;
  localparam logic [4:0] TAG_TX_DAT3  = 5'h0b;
  localparam logic [4:0] TAG_RX_DRD2  = 5'h0c;
  localparam logic [4:0] TAG_RX_DWB2  = 5'h0e;
  localparam logic [4:0] TAG_MNG_RD   = 5'h10;
  localparam logic [4:0] TAG_MNG_WR   = 5'h11;
  localparam logic [4:0] TAG_MSI      = 5'h1e;
  localparam logic [4:0] TAG_MSG      = 5'h1f;

  function automatic logic tag_ok(input logic [4:0] t);
    case (t)
      TAG_RX_DATA, TAG_RX_DRD, TAG_RX_DWB, TAG_TX_DRD, TAG_TX_DWB,
      TAG_TX_DRD2, TAG_TX_DWB2, TAG_TX_DAT0, TAG_TX_DAT1, TAG_TX_DAT2,
      TAG_TX_DAT3, TAG_RX_DRD2, TAG_RX_DWB2, TAG_MNG_RD, TAG_MNG_WR,
      TAG_MSI, TAG_MSG: tag_ok = 1'b1;
      default: tag_ok = 1'b0;
    endcase
  endfunction

  typedef struct packed {
    logic             blk;
    logic             xsync;
    logic             anydllp;
    logic             poison;
    logic             cto_seen;
    logic [4:0]       devnum;
    logic             pend_v;
    logic [4:0]       pend_tag;
    logic             pend_post;
    logic [31:0]      outst;
    logic [31:0]      retry;
    logic [31:0][4:0] age;
    logic [14:0]      ms_pre;
    logic [11:0]      upd_cnt;
    logic [12:0]      wd_cnt;
    logic [3:0]       updfc;
    logic             retrain;
    logic [7:0]       cred_p;
    logic [7:0]       cred_np;
    logic             tx_v;
    logic [4:0]       tx_tag;
    logic             tx_post;
    logic             req_ack;
    logic             deliver;
    logic             cpl_v;
    logic [4:0]       cpl_tag;
    logic             cpl_last;
    logic             cpl_unexp;
    logic             cto;
    logic [4:0]       cto_tag;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
  } state_t;

endpackage

// *** src/pcie_master_flow_control.sv ***
/*
  Transaction-layer master control: poison halt, master disable
  handshake, receive credit updates, upstream credit gating, FC
  watchdog, client tags and completion timeouts.
  Assumes all inputs synchronous to pclk and an APB master.
*/
// Design decisions made here: register access over APB and the register addresses.
// Behaviour
// - Poisoned TLP is dropped; mastering then halts until reset.
// - Registers stay reachable after a poison halt.
// - No master request while bus-master enable is off or in D3.
// - Block bit refuses new requests from every client.
// - Requests already pending still go out after blocking.
// - Any master reset, software reset included, clears the block bit.
// - Quiesce status reads zero only when blocked and idle.
// - Only the default virtual channel with one credit set.
// - Advertise PH 2, PD 16, NPH 2, NPD 2, completions infinite.
// - Freed NPD credit is returned and announced at once.
// - Any freed receive resource schedules an UpdateFC immediately.
// - Launch only with upstream credit of the needed type.
// - Periodic UpdateFC every 30 us, or 120 us with extended sync.
// - FC watchdog of 200 us restarted by FCPs or optionally any DLLP.
// - Watchdog expiry commands link retraining.
// - Device number captured from every type 0 config write.
// - Tag carries client ID; completions are routed by tag.
// - Data and descriptor clients use their fixed tag codes.
// - Other clients use 10, 11, 1E, 1F; other tags never used.
// - Completion timer runs between 10 ms and 50 ms per request.
// - Multi-completion read done only at last; timeout flagged.
// - A timed-out read is issued again.
// - Completions reach each client in request order.
module pcie_master_flow_control #(
  parameter int WD_CYC = pcie_fc_pkg::WD_CYC,
  parameter int MS_CYC = pcie_fc_pkg::MS_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        bme,
  input  wire logic        d3,
  input  wire logic        link_l0,
  input  wire logic        req_valid,
  input  wire logic [4:0]  req_tag,
  input  wire logic        req_posted,
  output logic             req_ack,
  output logic             tx_valid,
  output logic      [4:0]  tx_tag,
  output logic             tx_posted,
  input  wire logic        up_ret_p,
  input  wire logic        up_ret_np,
  input  wire logic        rx_tlp_valid,
  input  wire logic        rx_poison,
  output logic             rx_deliver,
  input  wire logic        cfg0_wr,
  input  wire logic [4:0]  cfg_devnum,
  input  wire logic        cpl_valid,
  input  wire logic [4:0]  cpl_tag,
  input  wire logic        cpl_last,
  output logic             cpl_out_valid,
  output logic      [4:0]  cpl_out_tag,
  output logic             cpl_out_last,
  output logic             cpl_unexpected,
  output logic             cto_err,
  output logic      [4:0]  cto_tag,
  input  wire logic [3:0]  rx_free,
  input  wire logic [3:0]  updfc_ack,
  output logic      [3:0]  updfc_req,
  input  wire logic        rx_fcp,
  input  wire logic        rx_dllp,
  output logic             retrain_req,
  output logic      [7:0]  adv_ph,
  output logic      [11:0] adv_pd,
  output logic      [7:0]  adv_nph,
  output logic      [11:0] adv_npd,
  output logic             adv_cpl_inf
);

  pcie_fc_pkg::state_t st_r;
  pcie_fc_pkg::state_t st_nxt;
  logic                wr;
  logic                sw_rst;
  logic                can_mst;
  logic                busy;
  logic                men;
  logic                rsel_v;
  logic [4:0]          rsel;
  logic                ms_tick;
  logic [11:0]         upd_last;

  //////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    st_nxt = st_r;
    st_nxt.req_ack   = 1'b0;
    st_nxt.retrain   = 1'b0;
    st_nxt.cto       = 1'b0;
    st_nxt.cpl_unexp = 1'b0;
    st_nxt.cpl_v     = 1'b0;
    st_nxt.tx_v      = 1'b0;
    st_nxt.pready    = 1'b0;
    st_nxt.pslverr   = 1'b0;
    rsel   = 5'h00;
    rsel_v = 1'b0;

    busy = st_r.pend_v | (|st_r.outst);
    men  = ~(st_r.blk & ~busy);
    wr   = psel & penable & st_r.pready & pwrite;
    sw_rst = wr && (paddr == pcie_fc_pkg::ADDR_CTRL)
             && pwdata[pcie_fc_pkg::CTRL_SWRST];

    // Register access never depends on master state
    if (psel && !penable) begin
      st_nxt.pready = 1'b1;
      st_nxt.prdata = 32'h0000_0000;
      if (paddr == pcie_fc_pkg::ADDR_CTRL) begin
        st_nxt.prdata[pcie_fc_pkg::CTRL_BLK]     = st_r.blk;
        st_nxt.prdata[pcie_fc_pkg::CTRL_XSYNC]   = st_r.xsync;
        st_nxt.prdata[pcie_fc_pkg::CTRL_ANYDLLP] = st_r.anydllp;
      end else if (paddr == pcie_fc_pkg::ADDR_STAT) begin
        st_nxt.prdata[pcie_fc_pkg::STAT_MEN]    = men;
        st_nxt.prdata[pcie_fc_pkg::STAT_POISON] = st_r.poison;
        st_nxt.prdata[pcie_fc_pkg::STAT_CTO]    = st_r.cto_seen;
      end else if (paddr == pcie_fc_pkg::ADDR_DEVN) begin
        st_nxt.prdata[4:0] = st_r.devnum;
      end else begin
        st_nxt.pslverr = 1'b1;
      end
    end
    if (wr && paddr == pcie_fc_pkg::ADDR_CTRL) begin
      st_nxt.blk     = pwdata[pcie_fc_pkg::CTRL_BLK];
      st_nxt.xsync   = pwdata[pcie_fc_pkg::CTRL_XSYNC];
      st_nxt.anydllp = pwdata[pcie_fc_pkg::CTRL_ANYDLLP];
    end
    if (wr && paddr == pcie_fc_pkg::ADDR_STAT
        && pwdata[pcie_fc_pkg::STAT_CTO]) begin
      st_nxt.cto_seen = 1'b0;
    end

    if (cfg0_wr) begin
      st_nxt.devnum = cfg_devnum;
    end

    st_nxt.deliver = rx_tlp_valid & ~rx_poison;
    if (rx_tlp_valid && rx_poison) begin
      st_nxt.poison = 1'b1;
    end
    can_mst = bme & ~d3 & ~st_r.poison;

    // Upstream credits, one set for the default channel
    st_nxt.cred_p  = st_r.cred_p + 8'(up_ret_p);
    st_nxt.cred_np = st_r.cred_np + 8'(up_ret_np);

    // Completions, routed by tag
    if (cpl_valid) begin
      if (st_r.outst[cpl_tag] && !st_r.retry[cpl_tag]) begin
        st_nxt.cpl_v    = 1'b1;
        st_nxt.cpl_tag  = cpl_tag;
        st_nxt.cpl_last = cpl_last;
        if (cpl_last) begin
          st_nxt.outst[cpl_tag] = 1'b0;
        end
      end else begin
        st_nxt.cpl_unexp = 1'b1;
      end
    end

    // Completion timers on a millisecond tick
    ms_tick = (st_r.ms_pre == 15'(MS_CYC - 1));
    st_nxt.ms_pre = ms_tick ? 15'h0000 : st_r.ms_pre + 15'h0001;
    for (int i = 0; i < 32; i++) begin
      if (st_r.outst[i] && !st_r.retry[i] && ms_tick) begin
        if (st_r.age[i] == pcie_fc_pkg::CTO_LAST) begin
          st_nxt.retry[i] = 1'b1;
          st_nxt.cto      = 1'b1;
          st_nxt.cto_tag  = 5'(i);
          st_nxt.cto_seen = 1'b1;
        end else begin
          st_nxt.age[i] = st_r.age[i] + 5'h01;
        end
      end
    end

    // Retries go first, lowest tag wins
    for (int i = 31; i >= 0; i--) begin
      if (st_r.retry[i]) begin
        rsel   = 5'(i);
        rsel_v = 1'b1;
      end
    end
    if (can_mst && rsel_v && st_r.cred_np != 8'h00) begin
      st_nxt.tx_v        = 1'b1;
      st_nxt.tx_tag      = rsel;
      st_nxt.tx_post     = 1'b0;
      st_nxt.retry[rsel] = 1'b0;
      st_nxt.age[rsel]   = 5'h00;
      st_nxt.cred_np     = st_nxt.cred_np - 8'h01;
    end else if (can_mst && st_r.pend_v) begin
      // Pending request leaves even while blocked
      if (st_r.pend_post && st_r.cred_p != 8'h00) begin
        st_nxt.tx_v    = 1'b1;
        st_nxt.tx_tag  = st_r.pend_tag;
        st_nxt.tx_post = 1'b1;
        st_nxt.pend_v  = 1'b0;
        st_nxt.cred_p  = st_nxt.cred_p - 8'h01;
      end else if (!st_r.pend_post && st_r.cred_np != 8'h00) begin
        st_nxt.tx_v    = 1'b1;
        st_nxt.tx_tag  = st_r.pend_tag;
        st_nxt.tx_post = 1'b0;
        st_nxt.pend_v  = 1'b0;
        st_nxt.cred_np = st_nxt.cred_np - 8'h01;
        st_nxt.outst[st_r.pend_tag] = 1'b1;
        st_nxt.age[st_r.pend_tag]   = 5'h00;
      end
    end

    // One request per tag, so each client sees its data in order
    if (req_valid && !st_r.pend_v && !st_r.blk && can_mst
        && pcie_fc_pkg::tag_ok(req_tag)
        && !st_r.outst[req_tag]) begin
      st_nxt.pend_v    = 1'b1;
      st_nxt.pend_tag  = req_tag;
      st_nxt.pend_post = req_posted;
      st_nxt.req_ack   = 1'b1;
    end

    // UpdateFC scheduling, set wins over acknowledge
    st_nxt.updfc = (st_r.updfc & ~updfc_ack) | rx_free;
    upd_last = st_r.xsync ? pcie_fc_pkg::UPD_XS_LAST
                          : pcie_fc_pkg::UPD_LAST;
    if (!link_l0) begin
      st_nxt.upd_cnt = 12'h000;
    end else if (st_r.upd_cnt == upd_last) begin
      st_nxt.upd_cnt = 12'h000;
      st_nxt.updfc   = pcie_fc_pkg::UPD_ALL;
    end else begin
      st_nxt.upd_cnt = st_r.upd_cnt + 12'h001;
    end

    // FC update watchdog
    if (!link_l0 || rx_fcp || (st_r.anydllp && rx_dllp)) begin
      st_nxt.wd_cnt = 13'h0000;
    end else if (st_r.wd_cnt == 13'(WD_CYC - 1)) begin
      st_nxt.wd_cnt  = 13'h0000;
      st_nxt.retrain = 1'b1;
    end else begin
      st_nxt.wd_cnt = st_r.wd_cnt + 13'h0001;
    end

    if (sw_rst) begin
      st_nxt.blk      = 1'b0;
      st_nxt.poison   = 1'b0;
      st_nxt.pend_v   = 1'b0;
      st_nxt.req_ack  = 1'b0;
      st_nxt.outst    = 32'h0000_0000;
      st_nxt.retry    = 32'h0000_0000;
      st_nxt.cto      = 1'b0;
      st_nxt.cto_seen = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r         <= '0;
      st_r.cred_p  <= pcie_fc_pkg::UP_CRED_INIT;
      st_r.cred_np <= pcie_fc_pkg::UP_CRED_INIT;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Advertised credits are fixed after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adv_ph      <= pcie_fc_pkg::ADV_PH;
      adv_pd      <= pcie_fc_pkg::ADV_PD;
      adv_nph     <= pcie_fc_pkg::ADV_NPH;
      adv_npd     <= pcie_fc_pkg::ADV_NPD;
      adv_cpl_inf <= 1'b1;
    end
  end

  assign prdata         = st_r.prdata;
  assign pready         = st_r.pready;
  assign pslverr        = st_r.pslverr;
  assign req_ack        = st_r.req_ack;
  assign tx_valid       = st_r.tx_v;
  assign tx_tag         = st_r.tx_tag;
  assign tx_posted      = st_r.tx_post;
  assign rx_deliver     = st_r.deliver;
  assign cpl_out_valid  = st_r.cpl_v;
  assign cpl_out_tag    = st_r.cpl_tag;
  assign cpl_out_last   = st_r.cpl_last;
  assign cpl_unexpected = st_r.cpl_unexp;
  assign cto_err        = st_r.cto;
  assign cto_tag        = st_r.cto_tag;
  assign updfc_req      = st_r.updfc;
  assign retrain_req    = st_r.retrain;

  //////////////////////////////////////////////////////////////////////
  // Checks

  chk_poison_drop: assert property (
    @(posedge pclk) disable iff (!presetn)
    rx_tlp_valid && rx_poison && !sw_rst |=> !rx_deliver && st_r.poison
  ) else $error("poisoned TLP delivered");
  chk_poison_halt: assert property (
    @(posedge pclk) disable iff (!presetn)
    st_r.poison |=> !tx_valid
  ) else $error("request sent after poison");
  chk_bme_off: assert property (
    @(posedge pclk) disable iff (!presetn)
    !bme || d3 |=> !tx_valid
  ) else $error("request sent while mastering disabled");
  chk_block_accept: assert property (
    @(posedge pclk) disable iff (!presetn)
    st_r.blk |=> !req_ack
  ) else $error("request accepted while blocked");
  chk_pend_kept: assert property (
    @(posedge pclk) disable iff (!presetn)
    st_r.blk && st_r.pend_v && !sw_rst |=> st_r.pend_v || tx_valid
  ) else $error("pending request lost");
  chk_read_busy: assert property (
    @(posedge pclk) disable iff (!presetn)
    tx_valid && !tx_posted && !$past(sw_rst) |-> men
  ) else $error("quiesce status low with read open");
  chk_credit_gate: assert property (
    @(posedge pclk) disable iff (!presetn)
    tx_valid && tx_posted |-> $past(st_r.cred_p) != 8'h00
  ) else $error("posted request without credit");
  chk_free_sched: assert property (
    @(posedge pclk) disable iff (!presetn)
    rx_free != 4'h0 |=> (updfc_req & $past(rx_free)) == $past(rx_free)
  ) else $error("freed resource not scheduled");
  chk_npd_return: assert property (
    @(posedge pclk) disable iff (!presetn)
    rx_free[3] |=> updfc_req[3] && adv_npd == pcie_fc_pkg::ADV_NPD
  ) else $error("NPD update missing");
  chk_wd_retrain: assert property (
    @(posedge pclk) disable iff (!presetn)
    link_l0 && !rx_fcp && !(st_r.anydllp && rx_dllp)
    && st_r.wd_cnt == 13'(WD_CYC - 1) |=> retrain_req
  ) else $error("watchdog expiry without retrain");
  chk_tag_legal: assert property (
    @(posedge pclk) disable iff (!presetn)
    tx_valid |-> pcie_fc_pkg::tag_ok(tx_tag)
  ) else $error("reserved tag sent");
  chk_unexp_cpl: assert property (
    @(posedge pclk) disable iff (!presetn)
    cpl_valid && !st_r.outst[cpl_tag] |=> cpl_unexpected && !cpl_out_valid
  ) else $error("unknown completion not dropped");
  chk_cto_retry: assert property (
    @(posedge pclk) disable iff (!presetn)
    cto_err |-> st_r.retry[cto_tag] ##1 (st_r.outst[cto_tag] || $past(sw_rst))
  ) else $error("timed-out read not queued again");
  chk_devnum_take: assert property (
    @(posedge pclk) disable iff (!presetn)
    cfg0_wr |=> st_r.devnum == $past(cfg_devnum)
  ) else $error("device number not captured");

endmodule

// *** sim/upstream_model.sv ***
/*
  Upstream port model: returns header credits, answers each read
  with two completions, acknowledges UpdateFC and sends FCPs.
  Assumes the link-side ports of the block and one clock.
*/
module upstream_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       ret_en,
  input  wire logic       cpl_en,
  input  wire logic       fcp_en,
  input  wire logic       bad_cpl,
  input  wire logic       tx_valid,
  input  wire logic [4:0] tx_tag,
  input  wire logic       tx_posted,
  input  wire logic [3:0] updfc_req,
  output logic            up_ret_p,
  output logic            up_ret_np,
  output logic            cpl_valid,
  output logic      [4:0] cpl_tag,
  output logic            cpl_last,
  output logic      [3:0] updfc_ack,
  output logic            rx_fcp
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] owed_p;
  logic [7:0] owed_np;
  logic [3:0] rd_v;
  logic [3:0] req_d;
  logic [3:0] fcp_n;
  logic [4:0] rd_t [4];
  logic       give_p;
  logic       give_np;
  logic       any_c;

  ////////////////////////////////////////////////////////////////////
  assign give_p  = ret_en && owed_p != 8'h00 && !up_ret_p;
  assign give_np = ret_en && owed_np != 8'h00 && !up_ret_np;
  assign any_c   = bad_cpl || rd_v[2] || rd_v[3];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      owed_p    <= 8'h00;
      owed_np   <= 8'h00;
      rd_v      <= 4'h0;
      req_d     <= 4'h0;
      fcp_n     <= 4'h0;
      rd_t      <= '{default: 5'h00};
      up_ret_p  <= 1'b0;
      up_ret_np <= 1'b0;
      cpl_valid <= 1'b0;
      cpl_tag   <= 5'h00;
      cpl_last  <= 1'b0;
      updfc_ack <= 4'h0;
      rx_fcp    <= 1'b0;
    end else begin
      // Credits are held back while returns are disabled
      owed_p    <= owed_p + 8'(tx_valid && tx_posted) - 8'(give_p);
      owed_np   <= owed_np + 8'(tx_valid && !tx_posted) - 8'(give_np);
      up_ret_p  <= give_p;
      up_ret_np <= give_np;
      rd_v      <= {rd_v[2:0], tx_valid && !tx_posted};
      rd_t      <= '{tx_tag, rd_t[0], rd_t[1], rd_t[2]};
      cpl_valid <= bad_cpl || (cpl_en && (rd_v[2] || rd_v[3]));
      cpl_tag   <= bad_cpl ? 5'h03 : rd_v[3] ? rd_t[3] :
                   rd_v[2] ? rd_t[2] : ~cpl_tag;
      cpl_last  <= any_c ? !rd_v[2] : ~cpl_last;
      req_d     <= updfc_req;
      updfc_ack <= req_d & updfc_req & ~updfc_ack;
      fcp_n     <= fcp_n + 4'h1;
      rx_fcp    <= fcp_en && fcp_n == 4'h0;
    end
  end
endmodule

// *** sim/testbench.sv ***
/*
  Self-checking bench for the PCIe master and flow-control block.
  Assumes upstream_model on the link side and APB register access.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, bme = 1'b1, d3 = 1'b0, link_l0 = 1'b0;
  logic [7:0]  paddr = 8'h00, adv_ph, adv_nph;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q;
  logic        pready, pslverr, req_ack, tx_valid, tx_posted, rx_deliver;
  logic        req_valid = 1'b0, req_posted = 1'b0, perr, a;
  logic [4:0]  req_tag = 5'h00, cfg_devnum = 5'h00, last_cpl;
  logic [5:0]  last_tx;
  logic [4:0]  tx_tag, cpl_tag, cpl_out_tag, cto_tag;
  logic        up_ret_p, up_ret_np, cpl_valid, cpl_last, cto_err;
  logic        rx_tlp_valid = 1'b0, rx_poison = 1'b0, cfg0_wr = 1'b0;
  logic        cpl_out_valid, cpl_out_last, cpl_unexpected, adv_cpl_inf;
  logic [3:0]  rx_free = 4'h0, updfc_ack, updfc_req;
  logic        rx_fcp, rx_dllp = 1'b0, retrain_req;
  logic [11:0] adv_pd, adv_npd;
  logic        ret_en = 1'b1, cpl_en = 1'b1, fcp_en = 1'b0, bad_cpl = 1'b0;
  int          errors = 0, check_count = 0, n_tx = 0, n_dlv = 0;
  int          n_c0 = 0, n_c1 = 0, n_unx = 0, n_rt = 0;

  always #20 pclk = ~pclk;

  pcie_master_flow_control #(.WD_CYC(50), .MS_CYC(20)) i_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .bme, .d3, .link_l0, .req_valid, .req_tag,
    .req_posted, .req_ack, .tx_valid, .tx_tag, .tx_posted, .up_ret_p,
    .up_ret_np, .rx_tlp_valid, .rx_poison, .rx_deliver, .cfg0_wr,
    .cfg_devnum, .cpl_valid, .cpl_tag, .cpl_last, .cpl_out_valid,
    .cpl_out_tag, .cpl_out_last, .cpl_unexpected, .cto_err, .cto_tag,
    .rx_free, .updfc_ack, .updfc_req, .rx_fcp, .rx_dllp, .retrain_req,
    .adv_ph, .adv_pd, .adv_nph, .adv_npd, .adv_cpl_inf
  );
  upstream_model i_up (
    .pclk, .presetn, .ret_en, .cpl_en, .fcp_en, .bad_cpl, .tx_valid,
    .tx_tag, .tx_posted, .updfc_req, .up_ret_p, .up_ret_np, .cpl_valid,
    .cpl_tag, .cpl_last, .updfc_ack, .rx_fcp
  );

  ////////////////////////////////////////////////////////////////////
  // Event counters on the link and client sides
  always @(posedge pclk) begin
    if (tx_valid === 1'b1) begin
      n_tx    <= n_tx + 1;
      last_tx <= {tx_posted, tx_tag};
    end
    if (cpl_out_valid === 1'b1) begin
      n_c0     <= n_c0 + int'(cpl_out_last !== 1'b1);
      n_c1     <= n_c1 + int'(cpl_out_last === 1'b1);
      last_cpl <= cpl_out_tag;
    end
    n_dlv <= n_dlv + int'(rx_deliver === 1'b1);
    n_unx <= n_unx + int'(cpl_unexpected === 1'b1);
    n_rt  <= n_rt + int'(retrain_req === 1'b1);
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    if (errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wait_on(input int w, input int lim, output int n);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while ((w == 0 ? req_ack : w == 1 ? cto_err : retrain_req) !== 1'b1
               && n < lim);
  endtask

  task automatic apb(input logic wr, input logic [7:0] ad,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= ad;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q    = prdata;
    perr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] ad);
    apb(1'b0, ad, 32'h0000_0000);
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d);
  endtask

  task automatic req(input logic [4:0] t, input logic p);
    int n;
    @(posedge pclk);
    req_valid  <= 1'b1;
    req_tag    <= t;
    req_posted <= p;
    wait_on(0, 20, n);
    a = req_ack === 1'b1;
    req_valid <= 1'b0;
    req_tag   <= ~t;
    repeat (12) @(posedge pclk);
  endtask

  task automatic gap(output int n);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (updfc_req === 4'hf && n < 5000);
    while (updfc_req !== 4'hf && n < 5000) begin
      @(posedge pclk);
      n++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    chk(adv_ph, 2'h2);
    chk(adv_pd, 5'h10);
    chk(adv_nph, 2'h2);
    chk(adv_npd, 2'h2);
    chk(adv_cpl_inf, 1'h1);
    rd(8'h00);
    chk(q, 1'h0);
    rd(8'h04);
    chk(q, 1'h1);
    rd(8'h0c);
    chk(perr, 1'h1);
    chk(q, 1'h0);
  endtask

  task automatic t_tags();
    logic [4:0] ok_t [17] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h05, 5'h06,
      5'h07, 5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0e, 5'h10, 5'h11,
      5'h1e, 5'h1f};
    logic [4:0] bad_t [4] = '{5'h03, 5'h0d, 5'h12, 5'h1d};
    int c0;
    int c1;
    c0 = n_c0;
    c1 = n_c1;
    foreach (ok_t[i]) begin
      req(ok_t[i], 1'b0);
      chk(a, 1'h1);
      chk(last_tx, ok_t[i]);
      chk(last_cpl, ok_t[i]);
    end
    chk(n_c0 - c0, 17);
    chk(n_c1 - c1, 17);
    foreach (bad_t[i]) begin
      req(bad_t[i], 1'b0);
      chk(a, 1'h0);
    end
  endtask

  task automatic t_misc();
    logic [4:0] dn [2] = '{5'h15, 5'h07};
    int u0;
    foreach (dn[i]) begin
      @(posedge pclk);
      cfg0_wr    <= 1'b1;
      cfg_devnum <= dn[i];
      @(posedge pclk);
      cfg0_wr    <= 1'b0;
      cfg_devnum <= ~dn[i];
      rd(8'h08);
      chk(q, dn[i]);
    end
    u0 = n_unx;
    @(posedge pclk);
    bad_cpl <= 1'b1;
    @(posedge pclk);
    bad_cpl <= 1'b0;
    repeat (4) @(posedge pclk);
    chk(n_unx - u0, 1);
  endtask

  task automatic t_updfc();
    for (int i = 0; i < 4; i++) begin
      @(posedge pclk);
      rx_free <= 4'h1 << i;
      @(posedge pclk);
      rx_free <= 4'h0;
      @(posedge pclk);
      chk(updfc_req[i], 1'h1);
      repeat (6) @(posedge pclk);
      chk(updfc_req, 4'h0);
    end
  endtask

  task automatic t_credit();
    int n0;
    ret_en <= 1'b0;
    n0 = n_tx;
    repeat (9) req(5'h00, 1'b1);
    chk(a, 1'h1);
    chk(n_tx - n0, 8);
    wr(8'h00, 4'h1);
    rd(8'h04);
    chk(q[0], 1'h1);
    ret_en <= 1'b1;
    repeat (30) @(posedge pclk);
    chk(n_tx - n0, 9);
    chk(last_tx, 6'h20);
    rd(8'h04);
    chk(q[0], 1'h0);
    req(5'h10, 1'b1);
    chk(a, 1'h0);
    wr(8'h00, 4'h8);
    rd(8'h00);
    chk(q, 1'h0);
    req(5'h00, 1'b1);
    chk(a, 1'h1);
  endtask

  task automatic t_bme();
    for (int i = 0; i < 2; i++) begin
      @(posedge pclk);
      bme <= i[0];
      d3  <= i[0];
      req(5'h08, 1'b0);
      chk(a, 1'h0);
    end
    bme <= 1'b1;
    d3  <= 1'b0;
  endtask

  task automatic t_poison();
    int d0;
    d0 = n_dlv;
    for (int i = 0; i < 2; i++) begin
      @(posedge pclk);
      rx_tlp_valid <= 1'b1;
      rx_poison    <= i[0];
      @(posedge pclk);
      rx_tlp_valid <= 1'b0;
      rx_poison    <= !i[0];
      repeat (3) @(posedge pclk);
      chk(n_dlv - d0, 1);
    end
    req(5'h04, 1'b0);
    chk(a, 1'h0);
    rd(8'h04);
    chk(q, 2'h3);
    wr(8'h00, 4'h8);
    req(5'h04, 1'b0);
    chk(a, 1'h1);
  endtask

  task automatic t_cto();
    int n0;
    int n;
    cpl_en <= 1'b0;
    req(5'h01, 1'b0);
    n0 = n_tx;
    wait_on(1, 1100, n);
    chk(n >= 189 && n <= 989, 1'h1);
    chk(cto_tag, 5'h01);
    cpl_en <= 1'b1;
    repeat (15) @(posedge pclk);
    chk(n_tx - n0, 1);
    chk(last_tx, 5'h01);
    chk(last_cpl, 5'h01);
    rd(8'h04);
    chk(q, 3'h5);
    wr(8'h00, 4'h8);
  endtask

  task automatic t_period();
    int n;
    link_l0 <= 1'b1;
    fcp_en  <= 1'b1;
    gap(n);
    gap(n);
    chk(n >= 750 && n <= 1125, 1'h1);
    wr(8'h00, 4'h2);
    gap(n);
    gap(n);
    chk(n >= 3000 && n <= 4500, 1'h1);
  endtask

  task automatic t_wd();
    int r0;
    int n;
    r0 = n_rt;
    repeat (200) @(posedge pclk);
    chk(n_rt - r0, 0);
    fcp_en <= 1'b0;
    wait_on(2, 200, n);
    chk(n >= 34 && n <= 76, 1'h1);
    wr(8'h00, 4'h4);
    r0 = n_rt;
    repeat (20) begin
      @(posedge pclk);
      rx_dllp <= 1'b1;
      @(posedge pclk);
      rx_dllp <= 1'b0;
      repeat (8) @(posedge pclk);
    end
    chk(n_rt - r0, 0);
    link_l0 <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_tags();
    t_misc();
    t_updfc();
    t_credit();
    t_bme();
    t_poison();
    t_cto();
    t_period();
    t_wd();
    test_done();
  end

  initial begin
    repeat (40000) @(posedge pclk);
    errors++;
    test_done();
  end
endmodule
